// File: adc_trigger_and_result_regs.sv
// converter control: apb registers, auto-trigger edge start, result formatting
//
// Our own choices: the address map and the APB register port.
`timescale 1ns/1ps
// Contract
// - trigger field decodes timers, comparators, logic cells
// - only rising edge of source starts conversion
// - timer wraps still raise their own flags
// - trigger field bits 7:4, low bits zero
// - left justify: high byte holds bits 9:2
// - left justify: low byte bits 7:6 hold 1:0
// - right justify: high byte bits 1:0 hold 9:8
// - right justify: low byte holds bits 7:0
// - result bytes read/write, kept across reset
// - completion clears go, sets flag, loads result
// - trigger edge sets go like software write
// - six unused result bits forced to zero
// - software stop loads partial, filled with last
module adc_trigger_and_result_regs
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire adc_trigger_pkg::trigger_sources_t trigger_sources,
  input wire logic comparator_decision,
  output logic converter_enable,
  output logic [4:0] input_channel_select,
  output logic [1:0] reference_select,
  output logic sample_hold,
  output logic [9:0] trial_code,
  output logic conversion_busy,
  output logic conversion_done_flag,
  output logic timer_zero_flag_set,
  output logic timer_one_flag_set
);

  // ==========================================================================
  // register storage
  logic [7:0] channel_run;
  logic [7:0] format_clock;
  logic [7:0] trigger_select;
  logic [7:0] result_high;
  logic [7:0] result_low;
  logic go;
  logic done_flag;
  logic selected_prev;
  logic [6:0] div_count;

  // ==========================================================================
  // bus decode
  wire access_phase;
  wire write_strobe;
  wire setup_read;
  wire hit_channel_run;
  wire hit_format_clock;
  wire hit_trigger_select;
  wire hit_result_high;
  wire hit_result_low;
  wire hit_status;
  wire hit_any;
  wire [7:0] write_byte;
  wire [31:0] read_word;

  // a write needs lane 0 for its byte; other lanes are ignored
  assign access_phase = psel && penable;
  assign write_strobe = access_phase && pwrite && hit_any && pstrb[0];
  assign setup_read = psel && !penable && !pwrite;
  assign write_byte = pwdata[7:0];
  assign hit_channel_run = (paddr == adc_trigger_pkg::OFFSET_CHANNEL_RUN);
  assign hit_format_clock = (paddr == adc_trigger_pkg::OFFSET_FORMAT_CLOCK);
  assign hit_trigger_select = (paddr == adc_trigger_pkg::OFFSET_TRIGGER_SELECT);
  assign hit_result_high = (paddr == adc_trigger_pkg::OFFSET_RESULT_HIGH);
  assign hit_result_low = (paddr == adc_trigger_pkg::OFFSET_RESULT_LOW);
  assign hit_status = (paddr == adc_trigger_pkg::OFFSET_STATUS);
  assign hit_any = hit_channel_run || hit_format_clock || hit_trigger_select
    || hit_result_high || hit_result_low || hit_status;

  // zero wait states; unmapped addresses answer with an error
  assign pready = 1'b1;
  assign pslverr = access_phase && !hit_any;

  // ==========================================================================
  // read multiplexer; go and done are live state, not stored bytes
  wire [7:0] channel_run_view;
  wire [7:0] status_view;

  assign channel_run_view = {1'b0, channel_run[adc_trigger_pkg::CHANNEL_MSB:adc_trigger_pkg::CHANNEL_LSB],
    go, channel_run[adc_trigger_pkg::ENABLE_BIT]};
  assign status_view = {7'h00, done_flag};
  assign read_word = hit_channel_run ? {24'h000000, channel_run_view}
    : hit_format_clock ? {24'h000000, format_clock}
    : hit_trigger_select ? {24'h000000, trigger_select}
    : hit_result_high ? {24'h000000, result_high}
    : hit_result_low ? {24'h000000, result_low}
    : hit_status ? {24'h000000, status_view}
    : 32'h00000000;

  // read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      prdata <= 32'h00000000;
    end
    else if (setup_read)
    begin
      prdata <= read_word;
    end
  end

  // ==========================================================================
  // trigger source selection
  wire [3:0] trig_code;
  wire trig_logic_cell;
  wire [1:0] cell_index;
  logic selected_source;

  assign trig_code = trigger_select[adc_trigger_pkg::TRIGGER_MSB:adc_trigger_pkg::TRIGGER_LSB];
  assign trig_logic_cell = (trig_code >= adc_trigger_pkg::TRIG_LOGIC_CELL_FIRST)
    && (trig_code <= adc_trigger_pkg::TRIG_LOGIC_CELL_LAST);
  assign cell_index = trig_code[1:0];

  // reserved codes land in the default arm and select a constant low
  always_comb
  begin
    selected_source = 1'b0;
    if (trig_logic_cell)
    begin
      selected_source = trigger_sources.logic_cell_out[cell_index];
    end
    else
    begin
      case (trig_code)
        adc_trigger_pkg::TRIG_TIMER_ZERO: selected_source = trigger_sources.timer_zero_wrap;
        adc_trigger_pkg::TRIG_TIMER_ONE: selected_source = trigger_sources.timer_one_wrap;
        adc_trigger_pkg::TRIG_TIMER_TWO: selected_source = trigger_sources.timer_two_period_hit;
        adc_trigger_pkg::TRIG_COMPARATOR_ONE: selected_source = trigger_sources.comparator_one_synced_out;
        adc_trigger_pkg::TRIG_COMPARATOR_TWO: selected_source = trigger_sources.comparator_two_synced_out;
        default: selected_source = 1'b0;
      endcase
    end
  end

  // a held-high source gives one start only, never a stream
  wire trigger_edge;
  assign trigger_edge = selected_source && !selected_prev;

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      selected_prev <= 1'b0;
    end
    else
    begin
      selected_prev <= selected_source;
    end
  end

  // timer wraps pass to their flag logic whatever the trigger choice
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      timer_zero_flag_set <= 1'b0;
      timer_one_flag_set <= 1'b0;
    end
    else
    begin
      timer_zero_flag_set <= trigger_sources.timer_zero_wrap;
      timer_one_flag_set <= trigger_sources.timer_one_wrap;
    end
  end

  // ==========================================================================
  // start, stop and go bit
  wire write_channel_run;
  wire software_start;
  wire start_request;
  wire abort_request;
  wire enable_now;
  wire result_valid;
  wire result_complete;
  wire [9:0] result_value;

  assign write_channel_run = write_strobe && hit_channel_run;
  assign enable_now = channel_run[adc_trigger_pkg::ENABLE_BIT];
  assign software_start = write_channel_run && write_byte[adc_trigger_pkg::GO_BIT]
    && write_byte[adc_trigger_pkg::ENABLE_BIT];
  // the acquisition wait is software's job; a trigger edge starts at once
  assign start_request = !go && (software_start || (trigger_edge && enable_now));
  // clearing go or enable mid-conversion stops it
  assign abort_request = go && write_channel_run
    && (!write_byte[adc_trigger_pkg::GO_BIT] || !write_byte[adc_trigger_pkg::ENABLE_BIT]);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      go <= 1'b0;
    end
    else if (start_request)
    begin
      go <= 1'b1;
    end
    else if (result_valid)
    begin
      go <= 1'b0;
    end
    else if (abort_request)
    begin
      go <= 1'b0;
    end
  end

  // ==========================================================================
  // conversion clock divider, restarted at each start
  logic [6:0] div_ratio;
  wire bit_tick;

  always_comb
  begin
    unique case (format_clock[adc_trigger_pkg::CLOCK_SEL_MSB:adc_trigger_pkg::CLOCK_SEL_LSB])
      3'h0: div_ratio = adc_trigger_pkg::DIV_BY_2;
      3'h1: div_ratio = adc_trigger_pkg::DIV_BY_8;
      3'h2: div_ratio = adc_trigger_pkg::DIV_BY_32;
      3'h3: div_ratio = adc_trigger_pkg::RC_CYCLES;
      3'h4: div_ratio = adc_trigger_pkg::DIV_BY_4;
      3'h5: div_ratio = adc_trigger_pkg::DIV_BY_16;
      3'h6: div_ratio = adc_trigger_pkg::DIV_BY_64;
      3'h7: div_ratio = adc_trigger_pkg::RC_CYCLES;
    endcase
  end

  assign bit_tick = go && (div_count == div_ratio - 7'h01);

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      div_count <= 7'h00;
    end
    else if (!go || bit_tick)
    begin
      div_count <= 7'h00;
    end
    else
    begin
      div_count <= div_count + 7'h01;
    end
  end

  // ==========================================================================
  // bit sequencer
  sar_sequencer u_sequencer
  (
    .pclk(pclk),
    .presetn(presetn),
    .start(start_request),
    .abort(abort_request),
    .bit_tick(bit_tick),
    .comparator_decision(comparator_decision),
    .sample_hold(sample_hold),
    .trial_code(trial_code),
    .result_valid(result_valid),
    .result_complete(result_complete),
    .result_value(result_value)
  );

  // ==========================================================================
  // control registers
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      channel_run <= adc_trigger_pkg::RESET_CHANNEL_RUN;
      format_clock <= adc_trigger_pkg::RESET_FORMAT_CLOCK;
      trigger_select <= adc_trigger_pkg::RESET_TRIGGER_SELECT;
    end
    else if (write_strobe)
    begin
      if (hit_channel_run)
      begin
        channel_run <= {1'b0, write_byte[6:0]};
      end
      if (hit_format_clock)
      begin
        format_clock <= {write_byte[7:4], 2'b00, write_byte[1:0]};
      end
      if (hit_trigger_select)
      begin
        trigger_select <= {write_byte[7:4], 4'h0};
      end
    end
  end

  // done flag: set wins over a write-one clear in the same cycle
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      done_flag <= 1'b0;
    end
    else if (result_valid && result_complete)
    begin
      done_flag <= 1'b1;
    end
    else if (write_strobe && hit_status && write_byte[adc_trigger_pkg::DONE_FLAG_BIT])
    begin
      done_flag <= 1'b0;
    end
  end

  // ==========================================================================
  // result formatting, zeros in the six unused places
  wire justify_right;
  wire [7:0] format_high;
  wire [7:0] format_low;

  assign justify_right = format_clock[adc_trigger_pkg::JUSTIFY_BIT];
  assign format_high = justify_right ? {6'h00, result_value[9:8]}
    : result_value[9:2];
  assign format_low = justify_right ? result_value[7:0]
    : {result_value[1:0], 6'h00};

  // no reset term: contents survive every reset and start unknown
  always_ff @(posedge pclk)
  begin
    if (result_valid)
    begin
      result_high <= format_high;
      result_low <= format_low;
    end
    else if (write_strobe)
    begin
      if (hit_result_high)
      begin
        result_high <= write_byte;
      end
      if (hit_result_low)
      begin
        result_low <= write_byte;
      end
    end
  end

  // ==========================================================================
  // outputs to the analog front end
  assign converter_enable = channel_run[adc_trigger_pkg::ENABLE_BIT];
  assign input_channel_select = channel_run[adc_trigger_pkg::CHANNEL_MSB:adc_trigger_pkg::CHANNEL_LSB];
  assign reference_select = format_clock[adc_trigger_pkg::REF_SEL_MSB:adc_trigger_pkg::REF_SEL_LSB];
  assign conversion_busy = go;
  assign conversion_done_flag = done_flag;

endmodule

// File: adc_trigger_chk.sv
// concurrent checks on the converter control block ports
`timescale 1ns/1ps
module adc_trigger_chk
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire adc_trigger_pkg::trigger_sources_t trigger_sources,
  input wire logic converter_enable,
  input wire logic conversion_busy,
  input wire logic conversion_done_flag,
  input wire logic timer_zero_flag_set,
  input wire logic timer_one_flag_set
);
  // ==========
  // write decode and a shadow of the trigger select field
  logic [3:0] trig_q;
  wire wr = psel && penable && pwrite && pstrb[0];
  wire wr0 = wr && paddr == adc_trigger_pkg::OFFSET_CHANNEL_RUN;
  wire wst = wr && paddr == adc_trigger_pkg::OFFSET_STATUS && pwdata[0];
  wire [8:0] s = trigger_sources;
  // source vector indexed by code; reserved codes land on constant zero
  wire [15:0] srcv = {4'h0, s[3:0], s[4], s[5], s[6], s[7], s[8], 3'h0};
  wire src = srcv[trig_q];
  wire valid = trig_q >= 4'h3 && trig_q <= 4'hB;
  // shadow follows only completed writes, so it matches what the block holds
  always_ff @(posedge pclk or negedge presetn)
    if (!presetn)
      trig_q <= 4'h0;
    else if (wr && paddr == adc_trigger_pkg::OFFSET_TRIGGER_SELECT)
      trig_q <= pwdata[7:4];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  // ==========
  // assertions
  a_tz_flag:
    assert property (s[8] |=> timer_zero_flag_set) else $error("timer zero flag missed");
  a_to_flag:
    assert property (s[7] |=> timer_one_flag_set) else $error("timer one flag missed");
  a_trig_read:
    assert property (psel && penable && !pwrite && paddr == adc_trigger_pkg::OFFSET_TRIGGER_SELECT
      |-> prdata == {24'h0, trig_q, 4'h0}) else $error("trigger select read wrong");
  a_edge_start:
    assert property (!conversion_busy && converter_enable && valid && $stable(trig_q) && src && !$past(src)
      && !wr0 |=> conversion_busy) else $error("trigger edge ignored");
  a_level_quiet:
    assert property (!conversion_busy && !wr0 && !(src && !$past(src)) |=> !conversion_busy)
      else $error("start without edge");
  a_reserved_quiet:
    assert property (!conversion_busy && !wr0 && !valid |=> !conversion_busy) else $error("start on idle code");
  a_done_go:
    assert property ($rose(conversion_done_flag) |-> $fell(conversion_busy)) else $error("done without go clear");
  a_done_kept:
    assert property (conversion_done_flag && !wst |=> conversion_done_flag) else $error("done flag lost");
  a_conv_bound:
    assert property ($rose(conversion_busy) |-> ##[1:720] !conversion_busy) else $error("conversion hangs");
  c_trig_start: cover property (valid && src && !$past(src) && !conversion_busy);
  c_done: cover property ($rose(conversion_done_flag));
  c_abort: cover property ($fell(conversion_busy) && !conversion_done_flag);
endmodule

bind adc_trigger_and_result_regs adc_trigger_chk i_adc_trigger_chk
(
  .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb, .prdata, .trigger_sources,
  .converter_enable, .conversion_busy, .conversion_done_flag, .timer_zero_flag_set, .timer_one_flag_set
);

// File: adc_trigger_pkg.sv
// shared constants, field layouts and carriers of the converter control block
package adc_trigger_pkg;

  // ==========================================================================
  // register byte offsets on the apb bus
  localparam logic [11:0] OFFSET_CHANNEL_RUN = 12'h000;
  localparam logic [11:0] OFFSET_FORMAT_CLOCK = 12'h004;
  localparam logic [11:0] OFFSET_TRIGGER_SELECT = 12'h008;
  localparam logic [11:0] OFFSET_RESULT_HIGH = 12'h00C;
  localparam logic [11:0] OFFSET_RESULT_LOW = 12'h010;
  localparam logic [11:0] OFFSET_STATUS = 12'h014;

  // ==========================================================================
  // field positions
  localparam int CHANNEL_MSB = 6;
  localparam int CHANNEL_LSB = 2;
  localparam int GO_BIT = 1;
  localparam int ENABLE_BIT = 0;
  localparam int JUSTIFY_BIT = 7;
  localparam int CLOCK_SEL_MSB = 6;
  localparam int CLOCK_SEL_LSB = 4;
  localparam int REF_SEL_MSB = 1;
  localparam int REF_SEL_LSB = 0;
  localparam int TRIGGER_MSB = 7;
  localparam int TRIGGER_LSB = 4;
  localparam int DONE_FLAG_BIT = 0;

  // ==========================================================================
  // reset values
  localparam logic [7:0] RESET_CHANNEL_RUN = 8'h00;
  localparam logic [7:0] RESET_FORMAT_CLOCK = 8'h00;
  localparam logic [7:0] RESET_TRIGGER_SELECT = 8'h00;

  // ==========================================================================
  // result geometry
  localparam int RESULT_BITS = 10;
  localparam logic [3:0] RESULT_TOP_INDEX = 4'h9;

  // ==========================================================================
  // trigger source codes
  localparam logic [3:0] TRIG_NONE = 4'h0;
  localparam logic [3:0] TRIG_TIMER_ZERO = 4'h3;
  localparam logic [3:0] TRIG_TIMER_ONE = 4'h4;
  localparam logic [3:0] TRIG_TIMER_TWO = 4'h5;
  localparam logic [3:0] TRIG_COMPARATOR_ONE = 4'h6;
  localparam logic [3:0] TRIG_COMPARATOR_TWO = 4'h7;
  localparam logic [3:0] TRIG_LOGIC_CELL_FIRST = 4'h8;
  localparam logic [3:0] TRIG_LOGIC_CELL_LAST = 4'hB;

  // ==========================================================================
  // conversion clock timing
  localparam int CLK_PERIOD_NS = 50;
  localparam int RC_PERIOD_NS = 2000;
  localparam int RC_CYCLES_INT = (RC_PERIOD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam logic [6:0] RC_CYCLES = 7'(RC_CYCLES_INT);
  localparam logic [6:0] DIV_BY_2 = 7'h02;
  localparam logic [6:0] DIV_BY_4 = 7'h04;
  localparam logic [6:0] DIV_BY_8 = 7'h08;
  localparam logic [6:0] DIV_BY_16 = 7'h10;
  localparam logic [6:0] DIV_BY_32 = 7'h20;
  localparam logic [6:0] DIV_BY_64 = 7'h40;

  // ==========================================================================
  // on-chip trigger sources, one bundle
  typedef struct packed {
    logic timer_zero_wrap;
    logic timer_one_wrap;
    logic timer_two_period_hit;
    logic comparator_one_synced_out;
    logic comparator_two_synced_out;
    logic [3:0] logic_cell_out;
  } trigger_sources_t;

  // sequencer states, gray along idle -> hold -> resolve; resolve -> idle flips both bits
  typedef enum logic [1:0] {
    SEQ_IDLE = 2'b00,
    SEQ_HOLD = 2'b01,
    SEQ_RESOLVE = 2'b11
  } seq_state_t;

endpackage

// File: analog_front_model.sv
// analog front end model answering the trial codes
`timescale 1ns/1ps
module analog_front_model
(
  input wire logic pclk,
  input wire logic slow,
  input wire logic conversion_busy,
  input wire logic [9:0] trial_code,
  input wire logic [9:0] level,
  output logic comparator_decision
);
  logic lag, idle_pat = 1'b0;
  wire fast = trial_code <= level;
  // slow mode answers a cycle late; idle line wanders
  always @(posedge pclk)
  begin
    lag <= fast;
    idle_pat <= ~idle_pat;
  end
  assign comparator_decision = !conversion_busy ? idle_pat : slow ? lag : fast;
endmodule

// File: sar_sequencer.sv
// successive-approximation bit sequencer with early-stop fill
`timescale 1ns/1ps
module sar_sequencer
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic start,
  input wire logic abort,
  input wire logic bit_tick,
  input wire logic comparator_decision,
  output logic sample_hold,
  output logic [9:0] trial_code,
  output logic result_valid,
  output logic result_complete,
  output logic [9:0] result_value
);

  adc_trigger_pkg::seq_state_t state;
  adc_trigger_pkg::seq_state_t next_state;
  logic [3:0] bit_idx;
  logic [9:0] code;
  logic last_bit;
  logic in_resolve;
  logic final_tick;
  wire [9:0] resolved_code;
  wire [9:0] partial_code;

  // ==========================================================================
  // per-bit trial, resolve and fill terms
  assign in_resolve = (state == adc_trigger_pkg::SEQ_RESOLVE);
  assign final_tick = in_resolve && bit_tick && (bit_idx == 4'h0);
  // nothing resolved yet means the fill value is zero
  assign last_bit = (in_resolve && bit_idx != adc_trigger_pkg::RESULT_TOP_INDEX) ? code[bit_idx + 4'h1] : 1'b0;

  genvar i;
  generate
    for (i = 0; i < adc_trigger_pkg::RESULT_BITS; i = i + 1)
    begin : g_bit
      assign resolved_code[i] = (bit_idx == 4'(i)) ? comparator_decision : code[i];
      // unresolved bits copy the last one decided
      assign partial_code[i] = (!in_resolve || bit_idx >= 4'(i)) ? last_bit : code[i];
      assign trial_code[i] = code[i] | (in_resolve && bit_idx == 4'(i));
    end
  endgenerate

  assign sample_hold = (state == adc_trigger_pkg::SEQ_HOLD);

  // ==========================================================================
  // state transitions
  always_comb
  begin
    next_state = state;
    unique case (state)
      adc_trigger_pkg::SEQ_IDLE:
      begin
        if (start)
        begin
          next_state = adc_trigger_pkg::SEQ_HOLD;
        end
      end
      adc_trigger_pkg::SEQ_HOLD:
      begin
        if (abort)
        begin
          next_state = adc_trigger_pkg::SEQ_IDLE;
        end
        else if (bit_tick)
        begin
          next_state = adc_trigger_pkg::SEQ_RESOLVE;
        end
      end
      adc_trigger_pkg::SEQ_RESOLVE:
      begin
        if (abort || final_tick)
        begin
          next_state = adc_trigger_pkg::SEQ_IDLE;
        end
      end
      default:
      begin
        next_state = adc_trigger_pkg::SEQ_IDLE;
      end
    endcase
  end

  // state, bit pointer and working code
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      state <= adc_trigger_pkg::SEQ_IDLE;
      bit_idx <= 4'h0;
      code <= 10'h000;
    end
    else
    begin
      state <= next_state;
      if (start && state == adc_trigger_pkg::SEQ_IDLE)
      begin
        bit_idx <= adc_trigger_pkg::RESULT_TOP_INDEX;
        code <= 10'h000;
      end
      else if (in_resolve && bit_tick && !abort)
      begin
        code <= resolved_code;
        bit_idx <= bit_idx - 4'h1;
      end
    end
  end

  // result word and its one-cycle strobe
  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      result_valid <= 1'b0;
      result_complete <= 1'b0;
      result_value <= 10'h000;
    end
    else
    begin
      result_valid <= 1'b0;
      if (abort && state != adc_trigger_pkg::SEQ_IDLE)
      begin
        result_valid <= 1'b1;
        result_complete <= 1'b0;
        result_value <= partial_code;
      end
      else if (final_tick)
      begin
        result_valid <= 1'b1;
        result_complete <= 1'b1;
        result_value <= resolved_code;
      end
    end
  end

endmodule

// File: tb.sv
// self-checking bench for the converter control block
`timescale 1ns/1ps
module tb;
  localparam logic [11:0] A_RUN = adc_trigger_pkg::OFFSET_CHANNEL_RUN;
  localparam logic [11:0] A_FMT = adc_trigger_pkg::OFFSET_FORMAT_CLOCK;
  localparam logic [11:0] A_TRIG = adc_trigger_pkg::OFFSET_TRIGGER_SELECT;
  localparam logic [11:0] A_HI = adc_trigger_pkg::OFFSET_RESULT_HIGH;
  localparam logic [11:0] A_LO = adc_trigger_pkg::OFFSET_RESULT_LOW;
  localparam logic [11:0] A_ST = adc_trigger_pkg::OFFSET_STATUS;
  localparam int ACQ = 100; // 5 us acquisition margin
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic slow = 1'b0;
  logic rnd_src = 1'b1;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [9:0] level = 10'h000;
  logic [31:0] seed = 32'hD7A2;
  adc_trigger_pkg::trigger_sources_t ts = 9'h000;
  logic [31:0] prdata, rv;
  logic [9:0] trial_code;
  logic [4:0] input_channel_select;
  logic [1:0] reference_select;
  logic pready, pslverr, e, comparator_decision, converter_enable, sample_hold;
  logic conversion_busy, conversion_done_flag, timer_zero_flag_set, timer_one_flag_set;
  int n_errors = 0;
  int compares = 0;
  int j, n, c;
  // device and its analog partner; all byte lanes enabled
  adc_trigger_and_result_regs i_adc_trigger_and_result_regs
  (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .pstrb(4'hF), .prdata, .pready, .pslverr,
    .trigger_sources(ts), .comparator_decision, .converter_enable, .input_channel_select, .reference_select,
    .sample_hold, .trial_code, .conversion_busy, .conversion_done_flag, .timer_zero_flag_set, .timer_one_flag_set
  );
  analog_front_model i_analog_front_model
  (
    .pclk, .slow, .conversion_busy, .trial_code, .level, .comparator_decision
  );
  initial
    forever #25 pclk = ~pclk;
  // ==========
  // helpers and reference model
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  // k resolved bits; the rest copy the last one resolved, zero if none
  function automatic logic [9:0] sar(input logic [9:0] t, input int k);
    logic [9:0] r;
    int b;
    r = t;
    for (b = 9 - k; b >= 0; b--)
      r[b] = (k == 0) ? 1'b0 : t[10 - k];
    return r;
  endfunction
  function automatic logic [15:0] fmt(input logic [9:0] r, input logic jr);
    return jr ? {6'h00, r} : {r, 6'h00};
  endfunction
  task automatic chk(input string name, input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      n_errors++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // one transfer, held until pready is sampled high
  task automatic apb(input logic [11:0] a, input logic [31:0] d, input logic w);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rv = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rdc(input string name, input logic [11:0] a, input logic [31:0] x);
    apb(a, 32'h0, 1'b0);
    chk(name, rv, x);
  endtask
  task automatic wait_idle();
    int i;
    for (i = 0; i < 2000 && (i == 0 || conversion_busy !== 1'b0); i++)
      @(posedge pclk);
    chk("busy", {31'h0, conversion_busy}, 32'h0);
  endtask
  // full conversion if hold_c is 0, else a software stop after k bits
  task automatic run_conv(input logic jr, input logic [2:0] cs, input int hold_c, input int k);
    logic [4:0] ch;
    logic [15:0] x;
    level <= 10'(rnd());
    ch = 5'(rnd());
    apb(A_FMT, {24'h0, jr, cs, 2'h0, ch[1:0]}, 1'b1);
    apb(A_RUN, {25'h0, ch, 2'b01}, 1'b1);
    repeat (ACQ) @(posedge pclk);
    chk("channel", {25'h0, input_channel_select, reference_select}, {25'h0, ch, ch[1:0]});
    apb(A_RUN, {25'h0, ch, 2'b11}, 1'b1);
    if (hold_c > 0)
    begin
      repeat (hold_c) @(posedge pclk);
      apb(A_RUN, {25'h0, ch, 2'b01}, 1'b1);
    end
    wait_idle();
    repeat (2) @(posedge pclk);
    x = fmt(sar(level, k), jr);
    rdc("done flag", A_ST, {31'h0, k == 10});
    rdc("result high", A_HI, {24'h0, x[15:8]});
    rdc("result low", A_LO, {24'h0, x[7:0]});
    apb(A_ST, 32'h1, 1'b1);
  endtask
  task automatic finish_test();
    $display("compares %0d errors %0d", compares, n_errors);
    if (n_errors == 0 && compares > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  // random source levels under an idle select code
  always @(posedge pclk)
    if (rnd_src)
      ts <= 9'(rnd());
  // ==========
  // scenarios
  initial
  begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    rdc("trigger select", A_TRIG, 32'h0);
    apb(A_TRIG, 32'hFF, 1'b1);
    rdc("trigger select", A_TRIG, 32'hF0);
    apb(A_TRIG, 32'h0, 1'b1);
    apb(12'h018, 32'h0, 1'b0);
    chk("unmapped error", {31'h0, e}, 32'h1);
    for (j = 0; j < 2; j++)
      for (n = 0; n < 4; n++)
      begin
        slow <= n[0];
        run_conv(j[0], {j[0], n[1:0]}, 0, 10);
      end
    run_conv(1'b1, 3'h6, 286, 3);
    // result bytes survive a later reset
    apb(A_HI, 32'h5A, 1'b1);
    apb(A_LO, 32'hA5, 1'b1);
    rnd_src <= 1'b0;
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    ts <= 9'h000;
    rdc("result high kept", A_HI, 32'h5A);
    rdc("result low kept", A_LO, 32'hA5);
    // every select code: rising then steady source
    for (c = 0; c < 16; c++)
    begin
      apb(A_TRIG, {24'h0, c[3:0], 4'h0}, 1'b1);
      apb(A_RUN, 32'h1, 1'b1);
      @(posedge pclk);
      ts <= 9'h1FF;
      @(posedge pclk);
      #1;
      chk("timer zero flag", {31'h0, timer_zero_flag_set}, 32'h1);
      chk("timer one flag", {31'h0, timer_one_flag_set}, 32'h1);
      @(posedge pclk);
      #1;
      chk("auto start", {30'h0, conversion_busy, sample_hold}, {30'h0, {2{c >= 3 && c <= 11}}});
      wait_idle();
      repeat (30) @(posedge pclk);
      chk("steady level", {31'h0, conversion_busy}, 32'h0);
      ts <= 9'h000;
      apb(A_ST, 32'h1, 1'b1);
    end
    finish_test();
  end
  initial
  begin
    repeat (20000) @(posedge pclk);
    n_errors++;
    finish_test();
  end
endmodule
